// [acs_pkg.sv]
// package: constants and types for the channel select and sar sequencer
package acs_pkg;
  localparam int          RESULT_WIDTH     = 12;
  localparam int          ADDR_WIDTH       = 4;
  localparam logic [3:0]  ADDR_LAST_EXT    = 4'ha;
  localparam logic [3:0]  ADDR_TEST_MID    = 4'hb;
  localparam logic [3:0]  ADDR_TEST_LOW    = 4'hc;
  localparam logic [3:0]  ADDR_TEST_HIGH   = 4'hd;
  localparam logic [3:0]  ADDR_POWER_DOWN  = 4'he;
  localparam logic [11:0] CODE_MID         = 12'h800;
  localparam logic [11:0] CODE_ZERO        = 12'h000;
  localparam logic [11:0] CODE_FULL        = 12'hfff;
  localparam logic [4:0]  ADDR_EDGES       = 5'h04;
  localparam logic [1:0]  LEN_8            = 2'h1;
  localparam logic [1:0]  LEN_16           = 2'h3;
  localparam logic [4:0]  EDGES_8          = 5'h08;
  localparam logic [4:0]  EDGES_12         = 5'h0c;
  localparam logic [4:0]  EDGES_16         = 5'h10;
  localparam logic [3:0]  BIT_LAST         = 4'hb;
  localparam logic [13:0] MUX_NONE         = 14'h0000;
  // one cycle of 10 ns with every channel select switch open between channels
  localparam int          BREAK_NS         = 10;
  localparam int          CLK_NS           = 10;
  localparam int          BREAK_CYCLES     = (BREAK_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [1:0]  BREAK_CNT        = 2'(BREAK_CYCLES);

  typedef enum logic [1:0] {
    ACS_IDLE    = 2'b00,
    ACS_SAMPLE  = 2'b01,
    ACS_CONVERT = 2'b11,
    ACS_DONE    = 2'b10
  } acs_state_type;
endpackage

// [acs_sync.sv]
// two flip-flop synchroniser with edge detection on the second stage
module acs_sync
  import acs_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic d,
  output logic      q,
  output logic      fall
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } acs_sync_type;
  acs_sync_type r_reg, r_next;

  always_comb begin
    r_next    = r_reg;
    r_next.s1 = d;
    r_next.s2 = r_reg.s1;
    r_next.s3 = r_reg.s2;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign q    = r_reg.s2;
  assign fall = r_reg.s3 & ~r_reg.s2;
endmodule

// [acs_sequencer.sv]
// channel select, sampling window and sar sequencer of the converter
// Functional notes
// - addresses 0000 to 1010 select external inputs zero to ten.
// - 1011, 1100, 1101 select midpoint, low and high reference test inputs.
// - test selections ideally convert to 800, 000 and fff.
// - address 1110 is power-down, not a channel; enter standby.
// - sampling starts on fourth io clock falling edge, continues afterwards.
// - sampling ends, sample held, on final io clock falling edge.
// - selector opens old channel before closing the new one.
// - twelve trial steps after hold, msb first to lsb.
// - comparator high records 0 and drops weight, else keeps it.
// - code saturates at full scale and zero at the references.
// - address shifted in during first four io clocks of a cycle.
// - power-down takes effect on fourth falling edge; cycle still completes.
// - power-down after reset until non power-down address, then convert.
// - final io clock is edge 8, 12 or 16 per data length.
module acs_sequencer
  import acs_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        io_clock,
  input  wire logic        address_in,
  input  wire logic [1:0]  data_length,
  input  wire logic        cycle_restart,
  input  wire logic        comparator_high,
  input  wire logic        input_above_high,
  input  wire logic        input_below_low,
  output logic [10:0]      external_select,
  output logic [2:0]       test_select,
  output logic             sample_switch,
  output logic [11:0]      trial_weights,
  output logic             power_down,
  output logic             result_valid,
  output logic [11:0]      result_data,
  output logic             converting
);
  typedef struct packed {
    acs_state_type state;
    logic [4:0]    edge_cnt;
    logic [3:0]    addr;
    logic [4:0]    last_edge;
    logic [13:0]   mux;
    logic [13:0]   mux_pending;
    logic [1:0]    break_cnt;
    logic          sampling;
    logic          power_down;
    logic [3:0]    step;
    logic [11:0]   sar;
    logic          valid;
    logic [11:0]   result;
  } acs_seq_type;
  acs_seq_type r_reg, r_next;

  logic io_fall;
  logic addr_bit;

  // edge found from the synchronised copy, not from the first stage
  acs_sync io_sync (
    .clk  (clk),
    .rst  (rst),
    .d    (io_clock),
    .q    (),
    .fall (io_fall)
  );
  acs_sync data_sync (
    .clk  (clk),
    .rst  (rst),
    .d    (address_in),
    .q    (addr_bit),
    .fall ()
  );
  // one-hot switch vector: bits 0..10 external, 11..13 test inputs
  function automatic logic [13:0] decode(input logic [3:0] a);
    logic [13:0] m;
    m = MUX_NONE;
    if (a <= ADDR_LAST_EXT) begin
      m[a] = 1'b1;
    end else if (a <= ADDR_TEST_HIGH) begin
      m[a] = 1'b1;
    end
    // power-down and unused codes close nothing
    return m;
  endfunction

  function automatic logic [4:0] final_edge(input logic [1:0] len);
    logic [4:0] e;
    e = EDGES_12;
    if (len == LEN_8) begin
      e = EDGES_8;
    end else if (len == LEN_16) begin
      e = EDGES_16;
    end
    return e;
  endfunction

  always_comb begin
    logic [3:0]  new_addr;
    logic [11:0] bit_w;
    r_next   = r_reg;
    new_addr = {r_reg.addr[2:0], addr_bit};
    bit_w    = 12'h800 >> r_reg.step;
    r_next.valid = 1'b0;

    if (r_reg.break_cnt != 2'h0) begin
      r_next.break_cnt = r_reg.break_cnt - 2'h1;
      if (r_reg.break_cnt == 2'h1) begin
        r_next.mux = r_reg.mux_pending;
      end
    end

    unique case (r_reg.state)
      ACS_IDLE, ACS_SAMPLE: begin
        if (cycle_restart) begin
          r_next.edge_cnt = 5'h00;
          r_next.state    = ACS_IDLE;
          r_next.sampling = 1'b0;
        end else if (io_fall) begin
          r_next.edge_cnt = r_reg.edge_cnt + 5'h01;
          // address shifted in msb first on the first four edges
          if (r_reg.edge_cnt < ADDR_EDGES) begin
            r_next.addr = new_addr;
          end
          if (r_reg.edge_cnt + 5'h01 == ADDR_EDGES) begin
            r_next.last_edge = final_edge(data_length);
            r_next.power_down = (new_addr == ADDR_POWER_DOWN);
            r_next.mux        = MUX_NONE;
            r_next.mux_pending = decode(new_addr);
            r_next.break_cnt  = BREAK_CNT;
            // sampling opens on the fourth falling edge
            r_next.sampling = 1'b1;
            r_next.state    = ACS_SAMPLE;
          end else if (r_reg.state == ACS_SAMPLE &&
                       r_reg.edge_cnt + 5'h01 == r_reg.last_edge) begin
            r_next.sampling = 1'b0;
            r_next.edge_cnt = 5'h00;
            r_next.step     = 4'h0;
            r_next.sar      = CODE_MID;
            // powered down: cycle ends without a conversion
            r_next.state    = r_reg.power_down ? ACS_IDLE : ACS_CONVERT;
          end
        end
      end
      ACS_CONVERT: begin
        // one bit per step, msb first
        // comparator high drops the weight, low keeps it
        if (comparator_high) begin
          r_next.sar = r_reg.sar & ~bit_w;
        end
        if (r_reg.step != BIT_LAST) begin
          r_next.sar  = (comparator_high ? (r_reg.sar & ~bit_w) : r_reg.sar) | (bit_w >> 1);
          r_next.step = r_reg.step + 4'h1;
        end else begin
          r_next.state = ACS_DONE;
        end
      end
      ACS_DONE: begin
        // clamp at the references; low and high test codes follow from these
        if (input_above_high) begin
          r_next.result = CODE_FULL;
        end else if (input_below_low) begin
          r_next.result = CODE_ZERO;
        end else begin
          r_next.result = r_reg.sar;
        end
        // published only after the twelfth step
        r_next.valid = 1'b1;
        r_next.state = ACS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r_reg            <= '0;
      r_reg.state      <= ACS_IDLE;
      r_reg.last_edge  <= EDGES_12;
      r_reg.power_down <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  assign external_select = r_reg.power_down ? 11'h000 : r_reg.mux[10:0];
  assign test_select     = r_reg.power_down ? 3'h0 : r_reg.mux[13:11];
  assign sample_switch   = r_reg.sampling & ~r_reg.power_down;
  assign trial_weights   = r_reg.sar;
  assign power_down      = r_reg.power_down;
  assign result_valid    = r_reg.valid;
  assign result_data     = r_reg.result;
  assign converting      = (r_reg.state == ACS_CONVERT) || (r_reg.state == ACS_DONE);
endmodule

// [acs_sequencer_monitor.sv]
// port checker of the channel select and sar sequencer
module acs_sequencer_monitor
  import acs_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [10:0] external_select,
  input wire logic [2:0]  test_select,
  input wire logic        sample_switch,
  input wire logic [11:0] trial_weights,
  input wire logic        power_down,
  input wire logic        result_valid,
  input wire logic [11:0] result_data,
  input wire logic        converting
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_start; $rose(converting); endsequence
  sequence s_steps; !result_valid [*8] ##1 !result_valid [*5] ##1 result_valid; endsequence
  start_trial_a: assert property (s_start |-> trial_weights == CODE_MID)
    else $error("first trial word wrong");
  step_count_a: assert property (s_start |-> s_steps)
    else $error("result not after twelve steps");
  hold_convert_a: assert property ($fell(sample_switch) |-> ##[0:1] converting)
    else $error("no conversion after hold");
  valid_pulse_a: assert property (result_valid |=> !result_valid)
    else $error("valid longer than one cycle");
  result_hold_a: assert property (!result_valid |-> $stable(result_data))
    else $error("result changed without valid");
  pd_quiet_a: assert property (power_down |-> !sample_switch && !(|{external_select,
    test_select}))
    else $error("selection during power down");
  break_make_a: assert property ($changed({external_select, test_select}) &&
    |{external_select, test_select} |-> $past({external_select, test_select}) == 14'h0)
    else $error("no open gap on channel change");
  one_path_a: assert property ($onehot0({external_select, test_select}))
    else $error("two inputs connected");
  sample_open_a: assert property ($rose(sample_switch) |=> |{external_select, test_select})
    else $error("sampling without a closed input");
endmodule

bind acs_sequencer acs_sequencer_monitor u_mon (.*);

// [acs_host.sv]
// host serial port model: io clock and address bits
module acs_host
(
  output logic io_clock,
  output logic address_in
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    io_clock = 1'b0;
    address_in = 1'b0;
  end
  // msb first, never code 1111; clock stands low between frames
  task automatic frame(input logic [3:0] addr, input int edges);
    for (int i = 0; i < edges; i++) begin
      // bit changes at the rising edge, so it is stable around the fall
      address_in = (i < 4) ? addr[3 - i] : ~address_in;
      io_clock = 1'b1;
      #40;
      io_clock = 1'b0;
      #40;
    end
  endtask
endmodule

// [test_acs_sequencer.sv]
// testbench of the channel select and sar sequencer
module test_acs_sequencer;
  import acs_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, rst, io_clock, address_in, cycle_restart, comparator_high, hi, lo;
  logic [1:0] data_length;
  logic [10:0] external_select;
  logic [2:0] test_select;
  logic sample_switch, power_down, result_valid, converting;
  logic [11:0] trial_weights, result_data, target;
  int num_errors, compares, cycles;
  // trial word above the input means the summing node trips
  assign comparator_high = trial_weights > target;
  acs_host u_host (.io_clock(io_clock), .address_in(address_in));
  acs_sequencer u_acs_sequencer (.clk(clk), .rst(rst), .io_clock(io_clock),
    .address_in(address_in), .data_length(data_length), .cycle_restart(cycle_restart),
    .comparator_high(comparator_high), .input_above_high(hi), .input_below_low(lo),
    .external_select(external_select), .test_select(test_select),
    .sample_switch(sample_switch), .trial_weights(trial_weights), .power_down(power_down),
    .result_valid(result_valid), .result_data(result_data), .converting(converting));
  always #5 clk = ~clk;
  task automatic final_report();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 12000) begin
      num_errors++;
      final_report();
    end
  end
  task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic run(input logic [3:0] a, input int n, input logic [11:0] t, output logic got);
    @(posedge clk);
    #1 target = t;
    u_host.frame(a, n);
    got = 1'b0;
    repeat (60) begin
      @(negedge clk);
      if (result_valid === 1'b1) got = 1'b1;
    end
  endtask
  task automatic t_power_down(input logic was_down);
    logic got;
    check("pd_before", 16'(power_down), 16'(was_down));
    run(ADDR_POWER_DOWN, 12, 12'h123, got);
    check("pd_valid", 16'(got), 16'h0);
    check("pd_flag", 16'(power_down), 16'h1);
    check("pd_sel", 16'({external_select, test_select}), 16'h0);
  endtask
  task automatic t_channel(input logic [3:0] a);
    logic got;
    run(a, 12, {a, 8'h5a} ^ 12'h3c3, got);
    check("valid", 16'(got), 16'h1);
    check("result", 16'(result_data), 16'(target));
    check("ext_sel", 16'(external_select), a <= ADDR_LAST_EXT ? 16'h1 << a : 16'h0);
    check("test_sel", 16'(test_select), a > ADDR_LAST_EXT ? 16'h1 << (a - 4'hb) : 16'h0);
  endtask
  task automatic t_scale(input logic [3:0] a, input logic h, input logic l, input int n,
    input logic [11:0] exp);
    logic got;
    @(posedge clk);
    #1 hi = h;
    lo = l;
    data_length = (n == 8) ? LEN_8 : (n == 16) ? LEN_16 : 2'h2;
    run(a, n, 12'h800, got);
    check("scale_valid", 16'(got), 16'h1);
    check("scale_result", 16'(result_data), 16'(exp));
    // later scenarios expect the 12 edge length and no clamp
    @(posedge clk);
    #1 data_length = 2'h2;
    hi = 1'b0;
    lo = 1'b0;
  endtask
  // a cut frame must not leave its edge count behind
  task automatic t_restart();
    @(posedge clk);
    #1 u_host.frame(4'h3, 3);
    @(posedge clk);
    #1 cycle_restart = 1'b1;
    @(posedge clk);
    #1 cycle_restart = 1'b0;
    t_channel(4'h9);
  endtask
  initial begin
    logic dropped;
    clk = 1'b0;
    rst = 1'b1;
    data_length = 2'h2;
    cycle_restart = 1'b0;
    hi = 1'b0;
    lo = 1'b0;
    target = 12'h000;
    repeat (6) @(posedge clk);
    #1 rst = 1'b0;
    check("reset_pd", 16'(power_down), 16'h1);
    t_power_down(1'b1);
    for (int a = 0; a < 14; a++) t_channel(4'(a));
    t_restart();
    t_scale(ADDR_TEST_MID, 1'b0, 1'b0, 12, CODE_MID);
    t_scale(ADDR_TEST_LOW, 1'b0, 1'b1, 8, CODE_ZERO);
    t_scale(ADDR_TEST_HIGH, 1'b1, 1'b1, 16, CODE_FULL);
    t_scale(4'h5, 1'b0, 1'b0, 16, CODE_MID);
    t_power_down(1'b0);
    run(4'h7, 12, 12'h000, dropped);
    t_channel(4'h2);
    final_report();
  end
endmodule
